// >>> csf_pkg.sv
// Shared constants for the clock switch and fail-safe supervisor.
package csf_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CONFIG_OFS = 8'h08;
    localparam logic [7:0] FLAG_OFS   = 8'h0C;

    // Control register fields.
    localparam int SCS_LSB      = 0;
    localparam int IRCF_LSB     = 3;
    localparam int SPLLEN_BIT   = 7;
    localparam int T1EN_BIT     = 8;
    localparam int SLEEP_BIT    = 9;
    localparam int WAKE_BIT     = 10;
    localparam int IRQEN_BIT    = 11;
    localparam logic [3:0] IRCF_RST = 4'h7;
    localparam logic [3:0] IRCF_PLL = 4'hE;

    // Status register fields.
    localparam int STS_T1R   = 7;
    localparam int STS_PLL_READY_FLAG  = 6;
    localparam int STS_START_UP_TIMEOUT_FLAG  = 5;
    localparam int STS_FAIL  = 8;
    localparam int STS_ASLP  = 9;

    // Configuration register fields.
    localparam int CFG_FOSC_LSB = 0;
    localparam int CFG_TWO_SPEED_ENABLE     = 3;
    localparam int CFG_CLOCK_MONITOR_ENABLE    = 4;
    localparam int CFG_PLLEN    = 5;
    localparam logic [5:0] CFG_RST = 6'h00;

    // ------------------------------------------------------------
    // Encodings and timing
    // ------------------------------------------------------------
    localparam logic [2:0] FOSC_LP     = 3'h0;
    localparam logic [2:0] FOSC_XT     = 3'h1;
    localparam logic [2:0] FOSC_HS     = 3'h2;
    localparam logic [2:0] FOSC_INTERNAL_OSC_BLOCK = 3'h4;
    localparam logic [1:0] SCS_CONFIG  = 2'h0;
    localparam logic [1:0] SCS_TIMER1  = 2'h1;

    localparam int OST_CYCLES   = 1024;
    localparam int SAMPLE_DIV   = 64;
    localparam int PLL_LOCK_CYC = 16;

    typedef enum logic [1:0] {
        CSF_SRC_INT,
        CSF_SRC_EXT,
        CSF_SRC_T1
    } csf_src_e;

endpackage

// >>> csf_fail_detect.sv
// Fail-safe latch: external falling edges against the sample clock.
module csf_fail_detect
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Events, already synchronised
    input  wire logic arm,
    input  wire logic ext_fall,
    input  wire logic smp_rise,
    input  wire logic smp_edge,
    // Result
    output logic      fail_pulse
);

    logic seen_q;

    // ------------------------------------------------------------
    // Latch set by the external clock, sampled on each half-cycle
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            seen_q <= 1'b0;
        else if (!arm || ext_fall)
            seen_q <= 1'b1;
        else if (smp_rise)
            seen_q <= 1'b0;
    end

    // A sample edge with no falling edge since the last sample rise is a failure.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fail_pulse <= 1'b0;
        else
            fail_pulse <= arm && smp_edge && !seen_q && !ext_fall;
    end

    AST_FAIL_NEEDS_ARM: assert property (@(posedge hclk) disable iff (!hresetn)
        fail_pulse |-> $past(arm))
        else $error("failure reported while monitor disarmed");

endmodule

// >>> csf_top.sv
// Clock source supervisor with two-speed start-up and fail-safe monitor.
// Notes on behaviour
// - Timeout flag reads 1 on external configured source, 0 on internal.
// - Timeout flag follows only crystal start timer, never Timer1 state.
// - Timer1 oscillator runs only while its enable bit is set.
// - PLL ready sets after switch to PLL, clears after switch back.
// - Crystal modes count 1024 oscillator cycles before becoming clock.
// - Two-speed start-up is off for any non-crystal oscillator mode.
// - Timer reaching 1024 while awake sets flag and moves to crystal.
// - Sleep aborts start-up timing and leaves timeout flag clear.
// - Two-speed needs enable bit, select field 00 and crystal mode; the start-up sequence here ignores the enable bit.
// - Two-speed starts after power-on reset and every wake-up.
// - Timer1 or crystal from sleep or reset costs 1024 cycles.
// - Run internal, count, wait internal fall, set flag, then switch.
// - Monitor works only when enabled and after start timer expiry.
// - Monitor covers crystal, external clock, RC and Timer1 modes.
// - Monitor sample clock is low-frequency oscillator divided by 64.
// - Latch set by external fall, cleared by sample rise.
// - Failure switches to internal clock and sets sticky fail flag.
// - Internal frequency after failure is the current IRCF field.
// - Reset, sleep or select change clears failure; change restarts timer.
// - Software clears fail flag; monitor is disarmed in fail-safe, so it is not set again.
// - Select 00 configured, 01 Timer1, 1x internal block.
// - Automatic switches leave select field; timeout flag shows source.
module csf_top
#(
    parameter int OST_COUNT = csf_pkg::OST_CYCLES,
    parameter int DIV_COUNT = csf_pkg::SAMPLE_DIV
)
(
    // AHB-Lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Oscillator pins, asynchronous to hclk
    input  wire logic        ext_osc,
    input  wire logic        t1_osc,
    input  wire logic        lf_osc,
    input  wire logic        int_osc,
    // Clock control outputs
    output logic      [1:0]  clk_source,
    output logic      [3:0]  clk_int_freq,
    output logic             clk_hold_low,
    output logic             t1_osc_run,
    output logic             pll_run,
    output logic             clock_fail_irq
);

    // ------------------------------------------------------------
    // Input synchronisers and edge detect
    // ------------------------------------------------------------
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic       ext_fall;
    logic       t1_fall;
    logic       lf_rise;
    logic       int_fall;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
        end
        else
        begin
            s1_q <= {int_osc, lf_osc, t1_osc, ext_osc};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign ext_fall = s3_q[0] && !s2_q[0];
    assign t1_fall  = s3_q[1] && !s2_q[1];
    assign lf_rise  = !s3_q[2] && s2_q[2];
    assign int_fall = s3_q[3] && !s2_q[3];

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        take;
    logic        wr_ctrl;
    logic [1:0]  scs_q;
    logic [3:0]  ircf_q;
    logic        spllen_q;
    logic        t1en_q;
    logic        irqen_q;
    logic [5:0]  cfg_q;
    logic        sleep_req;
    logic        wake_req;
    logic        asleep_q;
    logic        fail_flag_q;
    logic        fail_flag_clr;

    assign take    = hsel && hready && htrans[1];
    assign wr_ctrl = wr_pend_q && (wr_addr_q == csf_pkg::CTRL_OFS);
    assign sleep_req = wr_ctrl && hwdata[csf_pkg::SLEEP_BIT];
    assign wake_req  = wr_ctrl && hwdata[csf_pkg::WAKE_BIT] && asleep_q;
    assign fail_flag_clr = wr_pend_q && (wr_addr_q == csf_pkg::FLAG_OFS)
                           && hwdata[0];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= take && hwrite;
            wr_addr_q <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scs_q    <= csf_pkg::SCS_CONFIG;
            ircf_q   <= csf_pkg::IRCF_RST;
            spllen_q <= 1'b0;
            t1en_q   <= 1'b0;
            irqen_q  <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            scs_q    <= hwdata[csf_pkg::SCS_LSB +: 2];
            ircf_q   <= hwdata[csf_pkg::IRCF_LSB +: 4];
            spllen_q <= hwdata[csf_pkg::SPLLEN_BIT];
            t1en_q   <= hwdata[csf_pkg::T1EN_BIT];
            irqen_q  <= hwdata[csf_pkg::IRQEN_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cfg_q <= csf_pkg::CFG_RST;
        else if (wr_pend_q && (wr_addr_q == csf_pkg::CONFIG_OFS))
            cfg_q <= hwdata[5:0];
    end

    // ------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------
    logic [2:0] fosc;
    logic       crystal_mode;
    logic       ext_cfg;
    logic       two_speed_ok;
    logic       scs_change;

    assign fosc = cfg_q[csf_pkg::CFG_FOSC_LSB +: 3];
    assign crystal_mode = (fosc == csf_pkg::FOSC_LP) ||
                          (fosc == csf_pkg::FOSC_XT) ||
                          (fosc == csf_pkg::FOSC_HS);
    assign ext_cfg = (fosc != csf_pkg::FOSC_INTERNAL_OSC_BLOCK);
    // Two-speed needs all three settings at once.
    assign two_speed_ok = cfg_q[csf_pkg::CFG_TWO_SPEED_ENABLE] && crystal_mode
                          && (scs_q == csf_pkg::SCS_CONFIG);
    assign scs_change = wr_ctrl &&
                        (hwdata[csf_pkg::SCS_LSB +: 2] != scs_q);

    // ------------------------------------------------------------
    // Start-up timer and switch sequence
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_COUNT, ST_WAIT_INT, ST_HOLD, ST_RUN, ST_SLEEP
    } csf_st_e;

    csf_st_e     st_q;
    logic [10:0] ost_q;
    logic        start_up_timeout_flag_q;
    logic        osc_fall;
    logic        need_ost;

    // Timer1 counts its own edges; crystals count the external pin.
    assign osc_fall = (scs_q == csf_pkg::SCS_TIMER1) ? t1_fall : ext_fall;
    assign need_ost = crystal_mode || (scs_q == csf_pkg::SCS_TIMER1);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            asleep_q <= 1'b0;
        else if (sleep_req)
            asleep_q <= 1'b1;
        else if (wake_req)
            asleep_q <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q  <= ST_COUNT;
            ost_q <= 11'h000;
        end
        else if (sleep_req)
        begin
            st_q  <= ST_SLEEP;
            ost_q <= 11'h000;
        end
        else if (scs_change || wake_req)
        begin
            st_q  <= ST_COUNT;
            ost_q <= 11'h000;
        end
        else
        begin
            case (st_q)
                ST_COUNT:
                begin
                    if (!need_ost)
                        st_q <= ST_RUN;
                    else if (ost_q == 11'(OST_COUNT))
                        st_q <= ST_WAIT_INT;
                    else if (osc_fall)
                        ost_q <= ost_q + 11'h001;
                end
                ST_WAIT_INT:
                    if (int_fall)
                        st_q <= ST_HOLD;
                ST_HOLD:
                    if (osc_fall)
                        st_q <= ST_RUN;
                ST_RUN:
                    st_q <= ST_RUN;
                ST_SLEEP:
                    st_q <= ST_SLEEP;
                default:
                    st_q <= ST_COUNT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Fail-safe monitor
    // ------------------------------------------------------------
    logic [5:0] div_q;
    logic       smp_q;
    logic       smp_rise;
    logic       smp_edge;
    logic       mon_arm;
    logic       mon_clk_fall;
    logic       fail_pulse;
    logic       failsafe_q;

    assign smp_edge = lf_rise && (div_q == 6'(DIV_COUNT / 2 - 1));
    assign smp_rise = smp_edge && !smp_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q <= 6'h00;
            smp_q <= 1'b0;
        end
        else if (lf_rise)
        begin
            // Half of the divide ratio per sample-clock phase.
            if (smp_edge)
            begin
                div_q <= 6'h00;
                smp_q <= !smp_q;
            end
            else
                div_q <= div_q + 6'h01;
        end
    end

    // With the monitor enable bit set, any external source is watched once its start-up has finished.
    assign mon_arm = cfg_q[csf_pkg::CFG_CLOCK_MONITOR_ENABLE] && (st_q == ST_RUN)
                     && !failsafe_q && (ext_cfg || scs_q == csf_pkg::SCS_TIMER1)
                     && (scs_q[1] == 1'b0);
    assign mon_clk_fall = (scs_q == csf_pkg::SCS_TIMER1) ? t1_fall : ext_fall;

    csf_fail_detect u_detect
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .arm        (mon_arm),
        .ext_fall   (mon_clk_fall),
        .smp_rise   (smp_rise),
        .smp_edge   (smp_edge),
        .fail_pulse (fail_pulse)
    );

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            failsafe_q <= 1'b0;
        else if (sleep_req || scs_change)
            failsafe_q <= 1'b0;
        else if (fail_pulse)
            failsafe_q <= 1'b1;
    end

    // Set wins over a clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fail_flag_q <= 1'b0;
        else if (fail_pulse)
            fail_flag_q <= 1'b1;
        else if (fail_flag_clr)
            fail_flag_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Clock source selection and status
    // ------------------------------------------------------------
    logic       pll_want;
    logic [4:0] pll_cnt_q;
    logic       pll_ready_flag_q;

    assign pll_want = (fosc == csf_pkg::FOSC_INTERNAL_OSC_BLOCK) && (scs_q == 2'h0)
                      && (ircf_q == csf_pkg::IRCF_PLL)
                      && (spllen_q || cfg_q[csf_pkg::CFG_PLLEN]);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clk_source   <= csf_pkg::CSF_SRC_INT;
            clk_int_freq <= csf_pkg::IRCF_RST;
            clk_hold_low <= 1'b0;
            start_up_timeout_flag_q       <= 1'b0;
        end
        else
        begin
            clk_int_freq <= ircf_q;
            clk_hold_low <= (st_q == ST_HOLD);
            if (failsafe_q || scs_q[1] || (st_q != ST_RUN))
                clk_source <= csf_pkg::CSF_SRC_INT;
            else if (scs_q == csf_pkg::SCS_TIMER1)
                clk_source <= csf_pkg::CSF_SRC_T1;
            else if (ext_cfg)
                clk_source <= csf_pkg::CSF_SRC_EXT;
            else
                clk_source <= csf_pkg::CSF_SRC_INT;
            // Set in the hold phase, ahead of the switch itself.
            // Sleep or a new select drops the flag at once, not a cycle late.
            start_up_timeout_flag_q <= ext_cfg && (scs_q == csf_pkg::SCS_CONFIG) && !failsafe_q
                      && !sleep_req && !scs_change
                      && (st_q == ST_RUN || st_q == ST_HOLD);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            t1_osc_run     <= 1'b0;
            pll_run        <= 1'b0;
            clock_fail_irq <= 1'b0;
        end
        else
        begin
            t1_osc_run     <= t1en_q;
            pll_run        <= pll_want;
            clock_fail_irq <= fail_flag_q && irqen_q;
        end
    end

    // PLL ready follows a fixed lock count after the request settles.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pll_cnt_q <= 5'h00;
            pll_ready_flag_q    <= 1'b0;
        end
        else if (!pll_want)
        begin
            pll_cnt_q <= 5'h00;
            pll_ready_flag_q    <= 1'b0;
        end
        else if (pll_cnt_q == 5'(csf_pkg::PLL_LOCK_CYC))
            pll_ready_flag_q <= 1'b1;
        else
            pll_cnt_q <= pll_cnt_q + 5'h01;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
        begin
            case (haddr)
                csf_pkg::CTRL_OFS:
                    hrdata <= {20'h00000, irqen_q, asleep_q, t1en_q,
                               spllen_q, ircf_q, 1'b0, scs_q};
                csf_pkg::STATUS_OFS:
                    hrdata <= {22'h000000, asleep_q, failsafe_q,
                               t1_osc_run, pll_ready_flag_q, start_up_timeout_flag_q, 5'h00};
                csf_pkg::CONFIG_OFS:
                    hrdata <= {26'h0000000, cfg_q};
                csf_pkg::FLAG_OFS:
                    hrdata <= {31'h00000000, fail_flag_q};
                default:
                    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_SLEEP_CLEARS_START_UP_TIMEOUT_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        sleep_req |=> ##1 !start_up_timeout_flag_q)
        else $error("timeout flag set after sleep");
    AST_START_UP_TIMEOUT_FLAG_ONLY_EXT: assert property (@(posedge hclk) disable iff (!hresetn)
        start_up_timeout_flag_q |-> $past(ext_cfg))
        else $error("timeout flag set on internal configuration");
    AST_FAIL_TO_INT: assert property (@(posedge hclk) disable iff (!hresetn)
        fail_pulse |=> ##1 clk_source == csf_pkg::CSF_SRC_INT)
        else $error("failure did not move clock to internal source");
    AST_FLAG_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
        fail_flag_q && !fail_flag_clr |=> fail_flag_q)
        else $error("fail flag dropped without a clear");
    AST_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
        fail_pulse && fail_flag_clr |=> fail_flag_q)
        else $error("clear beat a new failure");
    AST_SCS_KEPT: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_ctrl |=> $stable(scs_q))
        else $error("select field moved without a write");
    AST_T1_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        t1_osc_run |-> $past(t1en_q))
        else $error("Timer1 oscillator runs while disabled");
    AST_NO_EARLY_SWITCH: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_q == ST_RUN) && need_ost && $past(st_q) == ST_HOLD
        |-> ost_q == 11'(OST_COUNT))
        else $error("crystal used before full start-up count");
    AST_PLL_READY_FLAG_DROP: assert property (@(posedge hclk) disable iff (!hresetn)
        !pll_want |=> !pll_ready_flag_q)
        else $error("PLL ready kept after leaving PLL mode");

    COV_FAIL: cover property (@(posedge hclk) fail_pulse);
    COV_SWITCH: cover property (@(posedge hclk) $rose(start_up_timeout_flag_q));
    COV_SLEEP: cover property (@(posedge hclk) sleep_req);
    COV_PLL: cover property (@(posedge hclk) $rose(pll_ready_flag_q));
    COV_TWO_SPEED: cover property (@(posedge hclk)
        two_speed_ok && st_q == ST_RUN);

endmodule

// >>> csf_osc_model.sv
// Behavioural oscillators seen at the supervisor's clock pins.
module csf_osc_model
(
    // Control from the bench
    input  wire logic stop_ext,
    // Oscillator pins
    output logic      ext_osc,
    output logic      t1_osc,
    output logic      lf_osc,
    output logic      int_osc
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        ext_osc = 1'b0;
        t1_osc  = 1'b0;
        lf_osc  = 1'b0;
        int_osc = 1'b0;
    end

    // A dead crystal freezes at its last level, as the real part would.
    always #30ns if (!stop_ext) ext_osc = ~ext_osc;
    always #35ns t1_osc = ~t1_osc;
    always #25ns lf_osc = ~lf_osc;
    always #15ns int_osc = ~int_osc;
endmodule

// >>> clock_switch_failsafe_tb.sv
// Self-checking bench for the clock supervisor.
module clock_switch_failsafe_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic hclk, hresetn, hsel, hwrite, stop_ext;
    logic [7:0] haddr;
    logic [1:0] htrans, clk_source;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, r;
    logic hreadyout, hresp, ext_osc, t1_osc, lf_osc, int_osc;
    logic [3:0] clk_int_freq;
    logic clk_hold_low, t1_osc_run, pll_run, clock_fail_irq;
    int n_mismatch = 0;
    int num_checks = 0;

    csf_osc_model i_csf_osc_model(.stop_ext(stop_ext), .ext_osc(ext_osc),
        .t1_osc(t1_osc), .lf_osc(lf_osc), .int_osc(int_osc));
    csf_top #(.OST_COUNT(8), .DIV_COUNT(8)) i_csf_top(.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_osc(ext_osc), .t1_osc(t1_osc),
        .lf_osc(lf_osc), .int_osc(int_osc), .clk_source(clk_source),
        .clk_int_freq(clk_int_freq), .clk_hold_low(clk_hold_low),
        .t1_osc_run(t1_osc_run), .pll_run(pll_run),
        .clock_fail_irq(clock_fail_irq));

    // ------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask

    // Polls one status bit; the caller judges the outcome.
    task automatic poll(input int b, input logic v);
        for (int i = 0; i < 400; i++)
        begin
            xfer(1'b0, csf_pkg::STATUS_OFS, 32'h0);
            if (r[b] === v) break;
        end
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        xfer(1'b0, csf_pkg::CTRL_OFS, 32'h0);
        chk("ctrl", r, 32'h0000_0038);
        chk("freq", {28'h0, clk_int_freq}, 32'h7);
        chk("hresp", {31'h0, hresp}, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        chk("unmapped", r, 32'h0);
    endtask

    task automatic t_two_speed();
        xfer(1'b1, csf_pkg::CONFIG_OFS, 32'h0000_0018);
        xfer(1'b1, csf_pkg::CTRL_OFS, 32'h0000_0238);
        xfer(1'b0, csf_pkg::STATUS_OFS, 32'h0);
        chk("start_up_timeout_flag_sleep", {31'h0, r[5]}, 32'h0);
        xfer(1'b1, csf_pkg::CTRL_OFS, 32'h0000_0438);
        chk("src_wake", {30'h0, clk_source}, 32'h0);
        poll(5, 1'b1);
        chk("start_up_timeout_flag", {31'h0, r[5]}, 32'h1);
        // The flag leads the switch by the hold phase.
        repeat (20) @(posedge hclk);
        chk("src_ext", {30'h0, clk_source}, 32'h1);
    endtask

    task automatic t_fail();
        stop_ext <= 1'b1;
        poll(8, 1'b1);
        chk("fail", {31'h0, r[8]}, 32'h1);
        chk("start_up_timeout_flag_fail", {31'h0, r[5]}, 32'h0);
        chk("src_fail", {30'h0, clk_source}, 32'h0);
        stop_ext <= 1'b0;
        xfer(1'b1, csf_pkg::CTRL_OFS, 32'h0000_0838);
        repeat (100) @(posedge hclk);
        xfer(1'b0, csf_pkg::FLAG_OFS, 32'h0);
        chk("flag", r, 32'h1);
        chk("irq", {31'h0, clock_fail_irq}, 32'h1);
        xfer(1'b1, csf_pkg::FLAG_OFS, 32'h1);
        xfer(1'b1, csf_pkg::CTRL_OFS, 32'h0000_083A);
        xfer(1'b1, csf_pkg::CTRL_OFS, 32'h0000_0838);
        poll(5, 1'b1);
        chk("refail", {31'h0, r[8]}, 32'h0);
        chk("irq_clr", {31'h0, clock_fail_irq}, 32'h0);
    endtask

    task automatic t_timer1();
        xfer(1'b1, csf_pkg::CTRL_OFS, 32'h0000_0138);
        poll(7, 1'b1);
        chk("t1_run", {31'h0, t1_osc_run}, 32'h1);
        // Software waits for the ready flag before selecting the source.
        xfer(1'b1, csf_pkg::CTRL_OFS, 32'h0000_0139);
        chk("t1_early", {31'h0, clk_source == 2'h2}, 32'h0);
        for (int i = 0; i < 400 && clk_source !== 2'h2; i++) @(posedge hclk);
        chk("t1_src", {30'h0, clk_source}, 32'h2);
    endtask

    task automatic t_pll();
        xfer(1'b1, csf_pkg::CONFIG_OFS, 32'h0000_0004);
        xfer(1'b1, csf_pkg::CTRL_OFS, 32'h0000_00F0);
        poll(6, 1'b1);
        chk("pll_ready_flag_set", {31'h0, r[6]}, 32'h1);
        chk("pll_run", {31'h0, pll_run}, 32'h1);
        xfer(1'b1, csf_pkg::CTRL_OFS, 32'h0000_0070);
        poll(6, 1'b0);
        chk("pll_ready_flag_clr", {31'h0, r[6]}, 32'h0);
        chk("pll_off", {31'h0, pll_run}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #2.5ns hclk = ~hclk;
    end

    initial
    begin
        {hresetn, hsel, hwrite, stop_ext} = 4'h0;
        haddr = 8'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_two_speed();
        t_fail();
        t_timer1();
        t_pll();
        end_of_test();
    end

    initial
    begin
        #200us;
        n_mismatch++;
        end_of_test();
    end
endmodule
